// [hdl/scac_serial_channel.sv]
// Behaviour
// [RQ1] Baud source: main clock or timer pin
// [RQ2] Transmit clock: baud tick or clock pin
// [RQ3] Receive clock: baud tick or clock pin
// [RQ4] Eleven-bit down-counter loaded from preset
// [RQ5] Prescaler divides by one or four
// [RQ6] Open-drain transmit when selected
// [RQ7] Transmit parity odd, zero, even, one
// [RQ8] Parity on both directions; receive odd/even
// [RQ9] Auto multidrop matches two stored addresses
// [RQ10] Submodes normal, multidrop, DDCMP framing; DDCMP submode runs as normal
// [RQ11] Hold stops transmit after current character
// [RQ12] Seven or eight bits; bit seven zeroed
// [RQ13] Request-to-send follows pending or enable
// [RQ14] One/two stops; fractional last stop
// [RQ15] Test paths normal, loopback, echo, software; software path runs as normal
// [RQ16] Each direction runs only when enabled
// [RQ17] Protocol family; asynchronous code served
// [RQ18] Events cleared only by writing one
// [RQ19] Software clears serviced events promptly
// [RQ20] Event bits: line changes and channel events
// [RQ21] Interrupt only for enabled events
// [RQ22] Busy when character dropped, no buffer
// [RQ23] Counter reload yields one baud tick
// [RQ24] Events set even when set; sticky
module scac_serial_channel
  import scac_pkg::*;
#(
  parameter int DIV_W = 11
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        timer_input_pin,
  input  wire logic        tx_clock_pin,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  input  wire logic        cd_n,
  output logic             txd_o,
  output logic             txd_oe_n,
  output logic             rts_n,
  output logic             irq
);
  // The divider field sits in bits 11:1 of its register.
  if (DIV_W != 11) begin : g_chk
    $error("DIV_W must be 11");
  end

  // Software-visible registers.
  logic [15:0] clk_q, mode_q;      // Clock and mode configuration.
  logic [2:0]  frac_q;             // Last stop length code.
  logic [7:0]  ev_q, mask_q;       // Events and their enables.
  logic [8:0]  txc_q;              // Pending character, bit 8 address.
  logic        txf_q;              // A character waits to be sent.
  logic [10:0] rxc_q;              // Stored character with flags.
  logic        rxf_q;              // Stored character not yet read.
  logic [15:0] adr_q;              // Two match addresses.
  logic [8:0]  ctl_q;              // Reject character and valid bit.
  logic        idle_q, cts_q, cd_q; // Quiet status and modem input history.

  // Bus data phase bookkeeping.
  logic        wr_q;               // A write data phase is due.
  logic [11:0] widx_q;             // Index of that write.

  // Field views.
  wire od = clk_q[CK_OD];
  wire [DIV_W-1:0] preset = clk_q[CK_DIV +: DIV_W];
  wire [1:0] sub = mode_q[MD_SUB +: 2];
  wire [1:0] diag = mode_q[MD_DIAG +: 2];
  wire fam_ok = mode_q[MD_FAM +: 2] == FAM_ASYNC;  // [RQ17]
  wire tx_on = mode_q[MD_TXON] && fam_ok;  // [RQ16]
  wire rx_on = mode_q[MD_RXON] && fam_ok;  // [RQ16]
  wire mdrop = sub == SUB_MDROP || sub == SUB_AUTO;  // [RQ10]
  wire extra = mdrop || mode_q[MD_PON];  // [RQ8]
  wire wide = mode_q[MD_WID];

  // Bus decode: address phase taken when selected and ready.
  wire         take = hsel && htrans[1] && hready && ce;
  wire [11:0]  aidx = haddr[13:2];
  wire         rd_rx = take && !hwrite && aidx == IDX_RXD;
  wire         wr_ok = wr_q && ce;
  wire [7:0]   ev_clr = (wr_ok && widx_q == IDX_EV) ? hwdata[7:0] : 8'h00;
  wire         wr_tx = wr_ok && widx_q == IDX_TXD;

  // Read mux; unmapped indices read zero.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (aidx == IDX_CLK) rmux[15:0] = clk_q;
    else if (aidx == IDX_MODE) rmux[15:0] = mode_q;
    else if (aidx == IDX_STOP) rmux[SF_POS +: 3] = frac_q;
    else if (aidx == IDX_EV) rmux[7:0] = ev_q;
    else if (aidx == IDX_MASK) rmux[7:0] = mask_q;
    else if (aidx == IDX_STAT) rmux[2:0] = {idle_q, cd_q, cts_q};
    else if (aidx == IDX_TXD) rmux[9:0] = {txf_q, txc_q};
    else if (aidx == IDX_RXD) rmux[11:0] = {rxf_q, rxc_q};
    else if (aidx == IDX_ADR) rmux[15:0] = adr_q;
    else if (aidx == IDX_CTL) rmux[8:0] = ctl_q;
  end

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase: capture write target, register read data.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      widx_q <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      wr_q <= take && hwrite && hsize == 3'h2;
      widx_q <= aidx;
      if (take && !hwrite) hrdata <= rmux;
    end
  end

  // Configuration writes land in the data phase.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_q <= 16'h0000;
      mode_q <= 16'h0000;
      frac_q <= SF_RESET;  // [RQ14]
      mask_q <= 8'h00;
      adr_q <= 16'h0000;
      ctl_q <= 9'h000;
    end else if (wr_ok) begin
      if (widx_q == IDX_CLK) clk_q <= hwdata[15:0];
      else if (widx_q == IDX_MODE) mode_q <= hwdata[15:0];
      else if (widx_q == IDX_STOP) frac_q <= hwdata[SF_POS +: 3];
      else if (widx_q == IDX_MASK) mask_q <= hwdata[7:0];
      else if (widx_q == IDX_ADR) adr_q <= hwdata[15:0];
      else if (widx_q == IDX_CTL) ctl_q <= hwdata[8:0];
    end
  end

  // Baud generator: source, prescaler, down-counter.
  logic            tin_q, tx_clock_pin_q;  // Previous pin levels for edges.
  logic [1:0]      pre_q;          // Prescaler phase.
  logic [DIV_W-1:0] cnt_q;         // Divider counter.
  wire src_tick = clk_q[CK_EXT] ? (timer_input_pin && !tin_q) : 1'b1;  // [RQ1]
  wire pre_tick = src_tick && (!clk_q[CK_QTR] || pre_q == 2'h3);  // [RQ5]
  wire baud_tick = pre_tick && cnt_q == '0;  // [RQ23]
  wire tx_clock_pin_rise = tx_clock_pin && !tx_clock_pin_q;
  wire tx_tick = (clk_q[CK_TXP] ? tx_clock_pin_rise : baud_tick) && ce;  // [RQ2]
  wire rx_tick = (clk_q[CK_RXP] ? tx_clock_pin_rise : baud_tick) && ce;  // [RQ3]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tin_q <= 1'b0;
      tx_clock_pin_q <= 1'b0;
      pre_q <= 2'h0;
      cnt_q <= '0;
    end else if (ce) begin
      tin_q <= timer_input_pin;
      tx_clock_pin_q <= tx_clock_pin;
      if (src_tick) pre_q <= pre_q + 2'h1;
      if (baud_tick) cnt_q <= preset;  // [RQ23]
      else if (pre_tick) cnt_q <= cnt_q - 1'b1;  // [RQ4]
    end
  end

  // Transmitter.
  scac_tx_t    tst_q;
  logic [11:0] tsh_q;   // Frame, LSB first.
  logic [3:0]  tleft_q; // Bits still to send.
  logic [3:0]  tsub_q;  // Sample within a bit.
  logic        tline_q; // Registered line level.
  wire [7:0] td = wide ? txc_q[7:0] : {1'b0, txc_q[6:0]};
  logic tpar;
  always_comb begin
    case (mode_q[MD_TPAR +: 2])  // [RQ7]
      PAR_ODD:  tpar = ~^td;
      PAR_ZERO: tpar = 1'b0;
      PAR_EVEN: tpar = ^td;
      default:  tpar = 1'b1;
    endcase
  end
  wire tx_x = mdrop ? txc_q[8] : (mode_q[MD_PON] ? tpar : 1'b1);
  wire [11:0] tframe = wide ? {2'b11, tx_x, td, 1'b0} : {3'b111, tx_x, td[6:0], 1'b0};
  wire [3:0] tbits = 4'(wide ? 9 : 8) + 4'(extra) + (mode_q[MD_STOP2] ? 4'h2 : 4'h1);  // [RQ14]
  wire [3:0] tlim = (tleft_q == 4'h1) ? FRAC_BASE + {1'b0, frac_q} : SUB_LAST;  // [RQ14]
  wire tx_start = tst_q == TX_IDLE && txf_q && tx_on && !mode_q[MD_HOLD] && tx_tick;  // [RQ11]
  wire tx_done = tst_q == TX_SHIFT && tx_tick && tsub_q == tlim && tleft_q == 4'h1;

  // Transmit state machine.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tst_q <= TX_IDLE;
      tsh_q <= 12'hFFF;
      tleft_q <= 4'h0;
      tsub_q <= 4'h0;
    end else if (ce) begin
      case (tst_q)
        TX_IDLE: begin
          if (tx_start) begin
            tst_q <= TX_SHIFT;
            tsh_q <= tframe;
            tleft_q <= tbits;
            tsub_q <= 4'h0;
          end
        end
        default: begin
          if (!tx_on) tst_q <= TX_IDLE;  // [RQ16]
          else if (tx_tick && tsub_q == tlim) begin
            tsub_q <= 4'h0;
            tsh_q <= {1'b1, tsh_q[11:1]};
            tleft_q <= tleft_q - 4'h1;
            if (tleft_q == 4'h1) tst_q <= TX_IDLE;
          end else if (tx_tick) tsub_q <= tsub_q + 4'h1;
        end
      endcase
    end
  end

  // Pending character: loaded by software, taken at frame start.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txc_q <= 9'h000;
      txf_q <= 1'b0;
    end else if (ce) begin
      if (wr_tx) txc_q <= hwdata[8:0];
      if (wr_tx) txf_q <= 1'b1;
      else if (tx_start) txf_q <= 1'b0;
    end
  end

  // Line drive with echo path; open-drain only pulls low.
  wire tx_bit = tst_q == TX_SHIFT ? tsh_q[0] : 1'b1;
  wire tline_d = diag == DG_ECHO ? rxd : (diag == DG_LOOP ? 1'b1 : tx_bit);  // [RQ15]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) tline_q <= 1'b1;
    else if (ce) tline_q <= tline_d;
  end
  assign txd_o = od ? 1'b0 : tline_q;  // [RQ6]
  assign txd_oe_n = od ? tline_q : 1'b0;  // [RQ6]
  assign rts_n = !(tx_on && (mode_q[MD_RTS] || txf_q || tst_q == TX_SHIFT));  // [RQ13]

  // Receiver; loopback feeds it from the transmit shifter.
  scac_rx_t    rst_q;
  logic [9:0]  rsh_q;   // Bits arrive at the top.
  logic [3:0]  rcnt_q;  // Bits sampled so far.
  logic [3:0]  rsub_q;  // Sample within a bit.
  logic        acc_q;   // Address matched in auto multidrop.
  wire rline = diag == DG_LOOP ? tx_bit : rxd;  // [RQ15]
  wire [3:0] rbits = 4'(wide ? 8 : 7) + 4'(extra) + 4'h1;
  wire [9:0] rsh_d = {rline, rsh_q[9:1]};
  wire [9:0] rfr = rsh_d >> (4'hA - rbits);
  wire [7:0] rdat = wide ? rfr[7:0] : {1'b0, rfr[6:0]};  // [RQ12]
  wire rx_x = rfr[wide ? 8 : 7];
  wire rstop = rfr[rbits - 4'h1];
  wire rperr = mode_q[MD_PON] && !mdrop && rx_x != (mode_q[MD_RPAR] ? ^rdat : ~^rdat);  // [RQ8]
  wire rend = rst_q == RX_BITS && rx_tick && rsub_q == SUB_LAST && rcnt_q == rbits - 4'h1;
  wire is_brk = rend && !rstop && rdat == 8'h00 && !rx_x;
  wire is_adr = rend && sub == SUB_AUTO && rx_x && !is_brk;
  wire hit = rdat == adr_q[7:0] || rdat == adr_q[15:8];  // [RQ9]
  wire is_ccr = rend && !is_brk && !is_adr && ctl_q[8] && rdat == ctl_q[7:0];
  wire deliver = rend && !is_brk && !is_adr && !is_ccr && (sub != SUB_AUTO || acc_q);  // [RQ9]
  wire busy = deliver && rxf_q && !rd_rx;  // [RQ22]
  wire store = deliver && !busy;

  // Receive state machine.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_q <= RX_IDLE;
      rsh_q <= 10'h000;
      rcnt_q <= 4'h0;
      rsub_q <= 4'h0;
    end else if (ce) begin
      case (rst_q)
        RX_IDLE: begin
          rsub_q <= 4'h0;
          if (rx_on && rx_tick && !rline) rst_q <= RX_START;
        end
        RX_START: begin
          if (!rx_on) rst_q <= RX_IDLE;  // [RQ16]
          else if (rx_tick && rsub_q == SUB_MID) begin
            rst_q <= rline ? RX_IDLE : RX_BITS;
            rsub_q <= 4'h0;
            rcnt_q <= 4'h0;
          end else if (rx_tick) rsub_q <= rsub_q + 4'h1;
        end
        default: begin
          if (!rx_on) rst_q <= RX_IDLE;  // [RQ16]
          else if (rx_tick && rsub_q == SUB_LAST) begin
            rsh_q <= rsh_d;
            rcnt_q <= rcnt_q + 4'h1;
            rsub_q <= 4'h0;
            if (rend) rst_q <= RX_IDLE;
          end else if (rx_tick) rsub_q <= rsub_q + 4'h1;
        end
      endcase
    end
  end

  // Received character store; a new store wins over a read.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxc_q <= 11'h000;
      rxf_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (ce) begin
      if (is_adr) acc_q <= hit;  // [RQ9]
      if (store) rxc_q <= {!rstop, rperr, rx_x, rdat};  // [RQ12]
      if (store) rxf_q <= 1'b1;
      else if (rd_rx) rxf_q <= 1'b0;
    end
  end

  // Line status: quiet detector and modem input history.
  logic [7:0] quiet_q;  // Samples of mark seen; status flops are declared with the registers.
  wire idle_d = quiet_q == IDLE_SUBS || cd_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 8'h00;
      idle_q <= 1'b1;  // Matches the idle level after reset, so no false change event.
      cts_q <= 1'b1;
      cd_q <= 1'b1;
    end else if (ce) begin
      if (!rline) quiet_q <= 8'h00;
      else if (rx_tick && rx_on && quiet_q != IDLE_SUBS) quiet_q <= quiet_q + 8'h01;
      idle_q <= idle_d;
      cts_q <= cts_n;
      cd_q <= cd_n;
    end
  end

  // Events: sets win over a write-one clear.
  wire [7:0] ev_set = {cts_n != cts_q, cd_n != cd_q, idle_d != idle_q, is_brk,
                       is_ccr, busy, tx_done, store};  // [RQ20]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) ev_q <= 8'h00;
    else if (ce) ev_q <= (ev_q & ~ev_clr) | ev_set;  // [RQ18] [RQ24]
  end
  assign irq = |(ev_q & mask_q);  // [RQ21]

  // Checks.
  sequence s_clr7;
    wr_ok && widx_q == IDX_EV && hwdata[7] && !ev_set[7];
  endsequence
  property p_w1c;
    @(posedge clock) disable iff (!resetn) s_clr7 |=> !ev_q[7];
  endproperty
  a_w1c: assert property (p_w1c) else $error("event not cleared");  // [RQ18]
  property p_keep;
    @(posedge clock) disable iff (!resetn) ev_q[0] && wr_ok && widx_q == IDX_EV && !hwdata[0] |=> ev_q[0];
  endproperty
  a_keep: assert property (p_keep) else $error("event lost on zero write");  // [RQ18]
  property p_set;
    @(posedge clock) disable iff (!resetn) ce && store |=> ev_q[0] && rxf_q;
  endproperty
  a_set: assert property (p_set) else $error("receive event missing");  // [RQ24]
  property p_irq;
    @(posedge clock) disable iff (!resetn) ce && ev_set[7] && !wr_ok |=> ev_q[7] && irq == mask_q[7];
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow its enable");  // [RQ21]
  property p_reload;
    @(posedge clock) disable iff (!resetn) ce && baud_tick |=> cnt_q == $past(preset);
  endproperty
  a_reload: assert property (p_reload) else $error("divider not reloaded");  // [RQ23]
  property p_rts;
    @(posedge clock) disable iff (!resetn) !tx_on |-> rts_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts with transmitter off");  // [RQ13]
  property p_hold;
    @(posedge clock) disable iff (!resetn) tst_q == TX_IDLE && mode_q[MD_HOLD] |=> tst_q == TX_IDLE;
  endproperty
  a_hold: assert property (p_hold) else $error("frame started while held");  // [RQ11]
  property p_od;
    @(posedge clock) disable iff (!resetn) od |-> !txd_o && txd_oe_n == tline_q;
  endproperty
  a_od: assert property (p_od) else $error("open-drain drives high");  // [RQ6]
  property p_w7;
    @(posedge clock) disable iff (!resetn) ce && store && !wide |=> !rxc_q[7];
  endproperty
  a_w7: assert property (p_w7) else $error("bit 7 not zero");  // [RQ12]
  property p_rxoff;
    @(posedge clock) disable iff (!resetn) ce && !rx_on |=> rst_q == RX_IDLE;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("receiver runs while off");  // [RQ16]
endmodule : scac_serial_channel

// [hdl/scac_pkg.sv]
package scac_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_CLK  = 12'h882;  // Clock and divider configuration.
  localparam logic [11:0] IDX_MODE = 12'h884;  // Channel mode configuration.
  localparam logic [11:0] IDX_STOP = 12'h886;  // Fractional stop configuration.
  localparam logic [11:0] IDX_EV   = 12'h888;  // Event flags, write one to clear.
  localparam logic [11:0] IDX_MASK = 12'h88A;  // Event enables.
  localparam logic [11:0] IDX_STAT = 12'h88C;  // Line status, read only.
  localparam logic [11:0] IDX_TXD  = 12'h88E;  // Transmit character.
  localparam logic [11:0] IDX_RXD  = 12'h890;  // Received character.
  localparam logic [11:0] IDX_ADR  = 12'h892;  // Two match addresses.
  localparam logic [11:0] IDX_CTL  = 12'h894;  // Reject control character.
  // Clock configuration fields.
  localparam int CK_OD = 15;  // Open-drain transmit.
  localparam int CK_EXT = 14;  // Baud source pin select.
  localparam int CK_RXP = 13;  // Receive clock pick.
  localparam int CK_TXP = 12;  // Transmit clock pick.
  localparam int CK_DIV = 1;  // Low bit of divider preset.
  localparam int CK_QTR = 0;  // Prescale by four.
  // Mode fields.
  localparam int MD_TPAR = 14;  // Transmit parity kind, two bits.
  localparam int MD_RPAR = 13;  // Receive parity odd/even.
  localparam int MD_PON = 12;  // Parity on.
  localparam int MD_SUB = 10;  // Async submode, two bits.
  localparam int MD_HOLD = 9;  // Transmit hold.
  localparam int MD_WID = 8;  // Character width select.
  localparam int MD_RTS = 7;  // Request-to-send policy.
  localparam int MD_STOP2 = 6;  // Two stop bits.
  localparam int MD_DIAG = 4;  // Test path select, two bits.
  localparam int MD_RXON = 3;  // Receive on.
  localparam int MD_TXON = 2;  // Transmit on.
  localparam int MD_FAM = 0;  // Protocol family, two bits.
  localparam int SF_POS = 12;  // Fraction field position.
  localparam logic [2:0] SF_RESET = 3'h7;  // Full-length last stop.
  // Encodings.
  localparam logic [1:0] FAM_ASYNC = 2'h1;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_MDROP = 2'h1;
  localparam logic [1:0] SUB_DDCMP = 2'h2;
  localparam logic [1:0] SUB_AUTO = 2'h3;
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] DG_LOOP = 2'h1;
  localparam logic [1:0] DG_ECHO = 2'h2;
  // Sixteen samples per bit; mid-bit of start is sample seven.
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] FRAC_BASE = 4'h8;
  localparam logic [7:0] IDLE_SUBS = 8'hA0;  // Ten bit times of mark.
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} scac_tx_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} scac_rx_t;
endpackage : scac_pkg

// [sim/scac_line_partner.sv]
// Remote asynchronous partner on the serial line: sends frames on rxd and
// decodes frames seen on the resolved transmit line.
module scac_line_partner (
  input  wire logic clock,
  input  wire logic txd_line,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clks = 32;  // Clocks per bit, set by the bench to match the baud setup.
  logic [9:0] cap;            // Data, extra bit and stop of the last frame heard.
  int         got_n = 0;      // Number of frames heard so far.

  // The line idles at mark, as a pulled-up receive line would.
  initial rxd = 1'b1;

  // Sends a start bit, n bits of the frame LSB first, then two bits of mark.
  task automatic send(input logic [8:0] frame, input int n);
    @(posedge clock);
    rxd <= 1'b0;
    repeat (bit_clks) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      rxd <= frame[i];
      repeat (bit_clks) @(posedge clock);
    end
    rxd <= 1'b1;
    repeat (2 * bit_clks) @(posedge clock);
  endtask

  // Listener: finds the start edge, then samples each later bit at its middle.
  initial forever begin : listen
    int bc;
    @(negedge txd_line);
    bc = bit_clks;
    repeat (bc / 2) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      repeat (bc) @(posedge clock);
      cap[i] = txd_line;
    end
    got_n++;
  end
endmodule // scac_line_partner

// [sim/scac_serial_channel_tb_top.sv]
// Self-checking bench for the serial channel configuration block.
module scac_serial_channel_tb_top;
  import scac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        timer_input_pin;
  logic        tx_clock_pin;
  logic        rxd;
  logic        cts_n;
  logic        cd_n;
  logic        txd_o;
  logic        txd_oe_n;
  logic        rts_n;
  logic        irq;
  logic [1:0]  pin_cnt;   // Free counter that makes the two clock pins.
  logic [31:0] rd;        // Last read data.
  int          bad_count;
  int          n_checks;
  // The transmit wire has a pull-up, so a released driver reads as mark.
  wire         txd_line = txd_oe_n ? 1'b1 : txd_o;

  scac_serial_channel i_scac_serial_channel (
    .clock(clock), .resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(), .timer_input_pin(timer_input_pin), .tx_clock_pin(tx_clock_pin),
    .rxd(rxd), .cts_n(cts_n), .cd_n(cd_n), .txd_o(txd_o), .txd_oe_n(txd_oe_n), .rts_n(rts_n), .irq(irq)
  );
  scac_line_partner i_scac_line_partner (.clock(clock), .txd_line(txd_line), .rxd(rxd));

  // Clock of 8 ns period.
  always #4 clock = ~clock;
  // Timer pin rises every 2 clocks, transmit clock pin every 4 clocks.
  always @(posedge clock) begin
    pin_cnt <= pin_cnt + 2'h1;
    timer_input_pin <= pin_cnt[0];
    tx_clock_pin <= pin_cnt[1];
  end

  // One single-word bus transfer; waits on hready in both phases.
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for one new frame at the partner and compares its content.
  task automatic wait_cap(input int n0, input logic [8:0] exp);
    for (int i = 0; i < 3000 && i_scac_line_partner.got_n == n0; i++) @(posedge clock);
    chk(32'(i_scac_line_partner.got_n - n0), 32'h1);
    chk({22'h0, i_scac_line_partner.cap}, {22'h0, 1'b1, exp});
  endtask

  // Queues one character and checks the frame that leaves the line.
  task automatic tx_char(input logic [7:0] d, input logic p);
    int n0;
    n0 = i_scac_line_partner.got_n;
    bus(1'b1, IDX_TXD, {24'h0, d});
    wait_cap(n0, {p, d});
  endtask

  // Reset values, a read/write field, and an unmapped place.
  task automatic t_reset();
    bus(1'b0, IDX_STOP, 32'h0);
    chk(rd, 32'h0000_7000);
    bus(1'b0, IDX_CLK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 12'h0FF, 32'hFFFF_FFFF);
    bus(1'b0, 12'h0FF, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, IDX_STOP, 32'h0000_3000);
    bus(1'b0, IDX_STOP, 32'h0);
    chk(rd, 32'h0000_3000);
  endtask

  // Both baud sources, both prescales, three divider presets and the clock pin must give the expected bit time.
  task automatic t_clocks();
    logic [15:0] cfg [5];
    int          bc [5];
    cfg = '{16'h0002, 16'h0003, 16'h000A, 16'h4000, 16'h1002};
    bc = '{32, 128, 96, 32, 64};
    bus(1'b1, IDX_MODE, 32'h1105);
    for (int i = 0; i < 5; i++) begin
      i_scac_line_partner.bit_clks = bc[i];
      bus(1'b1, IDX_CLK, {16'h0, cfg[i]});
      tx_char(8'hA7, 1'b0);
    end
    i_scac_line_partner.bit_clks = 32;
    bus(1'b1, IDX_CLK, 32'h0002);
  endtask

  // All four transmit parity kinds on a character with five ones.
  task automatic t_parity();
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, IDX_MODE, 32'h1105 | (k << 14));
      tx_char(8'hA7, k[1]);
    end
  endtask

  // Transmit off, hold, and a foreign family each keep a pending character back.
  task automatic t_blocked();
    logic [15:0] m [3];
    int          n0;
    m = '{16'h1101, 16'h1305, 16'h1104};
    for (int i = 0; i < 3; i++) begin
      n0 = i_scac_line_partner.got_n;
      bus(1'b1, IDX_MODE, {16'h0, m[i]});
      bus(1'b1, IDX_TXD, 32'h003C);
      repeat (800) @(posedge clock);
      chk(32'(i_scac_line_partner.got_n - n0), 32'h0);
      chk({31'h0, rts_n}, {31'h0, i != 1});
      bus(1'b1, IDX_MODE, 32'h1105);
      wait_cap(n0, 9'h13C);
    end
  endtask

  // Request-to-send under both policies and with the transmitter off.
  task automatic t_rts();
    logic [15:0] m [3];
    logic        e [3];
    m = '{16'h1185, 16'h1105, 16'h1181};
    e = '{1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, IDX_MODE, {16'h0, m[i]});
      #1;
      chk({31'h0, rts_n}, {31'h0, e[i]});
    end
  endtask

  // Open-drain output releases at mark and still carries a frame.
  task automatic t_open_drain();
    bus(1'b1, IDX_MODE, 32'h1105);
    bus(1'b1, IDX_CLK, 32'h8002);
    #1;
    chk({30'h0, txd_o, txd_oe_n}, 32'h1);
    tx_char(8'hA7, 1'b0);
    bus(1'b1, IDX_CLK, 32'h0002);
    #1;
    chk({30'h0, txd_o, txd_oe_n}, 32'h2);
  endtask

  // Receive parity, seven-bit width, dropped character and clearing of events.
  task automatic t_rx();
    bus(1'b1, IDX_EV, 32'h00FF);
    bus(1'b1, IDX_MODE, 32'h310D);
    i_scac_line_partner.send(9'h05A, 9);
    bus(1'b0, IDX_RXD, 32'h0);
    chk(rd & 32'hFFF, 32'h085A);
    i_scac_line_partner.send(9'h15A, 9);
    bus(1'b0, IDX_RXD, 32'h0);
    chk(rd & 32'hFFF, 32'h0B5A);
    bus(1'b1, IDX_MODE, 32'h100D);
    i_scac_line_partner.send(9'h0D5, 8);
    i_scac_line_partner.send(9'h0D5, 8);
    bus(1'b0, IDX_RXD, 32'h0);
    chk(rd & 32'hFFF, 32'h0955);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'h05, 32'h05);
    bus(1'b1, IDX_EV, 32'h0);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'h05, 32'h05);
    bus(1'b1, IDX_EV, 32'h00FF);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'hCF, 32'h0);
  endtask

  // Loopback in automatic multidrop: only data after a matching address is kept, the line stays at mark.
  task automatic t_loop();
    logic [8:0] c [4];
    int         n0;
    c = '{9'h134, 9'h055, 9'h177, 9'h066};
    n0 = i_scac_line_partner.got_n;
    bus(1'b1, IDX_ADR, 32'h0000_3412);
    bus(1'b1, IDX_MODE, 32'h0000_0D1D);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_TXD, {23'h0, c[i]});
      repeat (450) @(posedge clock);
      if (i[0]) begin
        bus(1'b0, IDX_RXD, 32'h0);
        chk(rd & 32'h0000_0FFF, i[1] ? 32'h0000_0055 : 32'h0000_0855);
      end
    end
    chk(32'(i_scac_line_partner.got_n - n0), 32'h0);
  endtask

  // Modem line changes, selective clearing and the enable mask on irq.
  task automatic t_events();
    @(posedge clock);
    cts_n <= 1'b0;
    repeat (8) @(posedge clock);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'hC0, 32'h80);
    cd_n <= 1'b0;
    repeat (8) @(posedge clock);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'hC0, 32'hC0);
    bus(1'b1, IDX_EV, 32'h0040);
    bus(1'b0, IDX_EV, 32'h0);
    chk(rd & 32'hC0, 32'h80);
    bus(1'b1, IDX_MASK, 32'h0080);
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, IDX_MASK, 32'h0040);
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: well beyond the roughly 12500 clocks that the tests need.
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  // Main sequence: drive every input at time zero, reset, then the scenarios.
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_input_pin = 1'b0;
    tx_clock_pin = 1'b0;
    cts_n = 1'b1;
    cd_n = 1'b1;
    pin_cnt = 2'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_clocks();
    t_parity();
    t_blocked();
    t_rts();
    t_open_drain();
    t_rx();
    t_loop();
    t_events();
    end_sim();
  end
endmodule // scac_serial_channel_tb_top
